//--- src/hsb_pkg.sv
// ****************************************************************
// Constants for the host serial settings bank
// ****************************************************************
package hsb_pkg;

    // Module clock rate
    localparam int unsigned CLK_HZ = 10_000_000;

    // Settings indices, decimal 101 to 106
    localparam logic [9:0] IDX_RATE    = 10'h065;
    localparam logic [9:0] IDX_WORD    = 10'h066;
    localparam logic [9:0] IDX_PARITY  = 10'h067;
    localparam logic [9:0] IDX_TIMEOUT = 10'h068;
    localparam logic [9:0] IDX_BUFCAP  = 10'h069;
    localparam logic [9:0] IDX_FLOW    = 10'h06a;

    // Values after reset
    localparam logic [7:0] RST_RATE    = 8'h02;
    localparam logic [7:0] RST_WORD    = 8'h08;
    localparam logic [7:0] RST_PARITY  = 8'h00;
    localparam logic [7:0] RST_TIMEOUT = 8'h08;
    localparam logic [7:0] RST_BUFCAP  = 8'h80;
    localparam logic [7:0] RST_FLOW    = 8'h00;

    // Accepted value ranges
    localparam logic [9:0] RATE_MAX    = 10'h009;
    localparam logic [9:0] WORD_MIN    = 10'h008;
    localparam logic [9:0] WORD_MAX    = 10'h009;
    localparam logic [9:0] PARITY_MAX  = 10'h004;
    localparam logic [9:0] TIMEOUT_MAX = 10'h0ff;
    localparam logic [9:0] FLOW_MAX    = 10'h001;

    // Decimal accumulator ceiling and overflow marker
    localparam logic [9:0] ACC_MAX     = 10'h3e7;
    localparam logic [9:0] ACC_OVF     = 10'h3ff;

    // Characters of the text command set
    localparam logic [7:0] CH_A    = 8'h41;
    localparam logic [7:0] CH_T    = 8'h54;
    localparam logic [7:0] CH_S    = 8'h53;
    localparam logic [7:0] CH_PLUS = 8'h2b;
    localparam logic [7:0] CH_EQ   = 8'h3d;
    localparam logic [7:0] CH_QM   = 8'h3f;
    localparam logic [7:0] CH_CR   = 8'h0d;
    localparam logic [7:0] CH_0    = 8'h30;
    localparam logic [7:0] CH_9    = 8'h39;
    localparam logic [7:0] CH_O    = 8'h4f;
    localparam logic [7:0] CH_E    = 8'h45;
    localparam logic [7:0] CH_ERR1 = 8'h31;

    // Escape runs: third repeated character completes the sequence
    localparam logic [1:0] RUN_LAST = 2'h2;

    // Reply layout: last position of each reply and query fields
    localparam logic [3:0] LAST_OK  = 4'h1;
    localparam logic [3:0] LAST_ERR = 4'h4;
    localparam logic [3:0] LAST_QRY = 4'ha;
    localparam logic [3:0] POS_VH   = 4'h7;
    localparam logic [3:0] POS_VT   = 4'h8;
    localparam logic [3:0] POS_VO   = 4'h9;

    // Parser states, Gray coded along the command path
    typedef enum logic [3:0] {
        HSB_BIN  = 4'h0,
        HSB_LINE = 4'h1,
        HSB_GOTA = 4'h3,
        HSB_GOTT = 4'h2,
        HSB_IDX  = 4'h6,
        HSB_VAL  = 4'h7,
        HSB_RESP = 4'h5,
        HSB_QRY  = 4'h4,
        HSB_SKIP = 4'hc
    } hsb_state_e;

    // Reply kinds
    typedef enum logic [1:0] {
        HSB_RSP_OK  = 2'h0,
        HSB_RSP_ERR = 2'h1,
        HSB_RSP_QRY = 2'h2
    } hsb_rsp_e;

    // Line rate in bits per second for each rate code
    function automatic int unsigned hsb_rate_bps(input logic [7:0] code);
        case (code)
            8'h00: return 115200;
            8'h01: return 57600;
            8'h02: return 38400;
            8'h03: return 19200;
            8'h04: return 9600;
            8'h05: return 4800;
            8'h06: return 2400;
            8'h07: return 1200;
            8'h08: return 28800;
            8'h09: return 600;
            default: return 38400;
        endcase
    endfunction

    // Clock cycles per bit, rounded to nearest
    function automatic logic [15:0] hsb_rate_div(input logic [7:0] code);
        int unsigned bps;
        bps = hsb_rate_bps(code);
        return 16'((CLK_HZ + bps / 2) / bps);
    endfunction

endpackage

//--- src/hsb_dec_ascii.sv
`timescale 1ns/1ns
// ****************************************************************
// Byte to three decimal ASCII digits
// ****************************************************************
module hsb_dec_ascii
    import hsb_pkg::*;
(
    // Binary value
    input  wire logic [7:0] value,
    // Decimal digits as characters
    output logic      [7:0] hund,
    output logic      [7:0] tens,
    output logic      [7:0] ones
);

    // Split into digits and offset to ASCII
    always_comb begin
        hund = CH_0 + (value / 8'h64);
        tens = CH_0 + ((value / 8'h0a) % 8'h0a);
        ones = CH_0 + (value % 8'h0a);
    end

endmodule

//--- src/hsb_settings_bank.sv
`timescale 1ns/1ns
// Operation
// - Every setting queried by decimal index, and all but index 105 written
// - Index 101 selects line rate, default 2
// - Index 102 word length 8 or 9
// - Index 103 parity scheme, default none
// - Index 104 timeout milliseconds, default 8
// - Index 105 reports 128, not writable
// - Index 106 flow control enable, default off
module hsb_settings_bank
    import hsb_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Received characters from the serial receiver
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    // Reply characters to the serial transmitter
    output logic            tx_valid,
    output logic      [7:0] tx_data,
    input  wire logic       tx_ready,
    // Settings seen by the serial port
    output logic      [7:0] serial_rate_select,
    output logic      [7:0] serial_word_length,
    output logic      [7:0] serial_parity_select,
    output logic      [7:0] serial_timeout_ms,
    output logic      [7:0] serial_buffer_capacity,
    output logic      [7:0] serial_flow_control_enable,
    // Port status
    output logic            text_command_mode,
    output logic            rate_tick
);

    // ****************************************************************
    // Decode helpers
    // ****************************************************************

    // One decimal digit appended, saturating to the overflow marker
    function automatic logic [9:0] acc_step(input logic [9:0] acc, input logic [3:0] d);
        logic [13:0] m;
        m = {4'h0, acc} * 14'h000a + {10'h000, d};
        return (acc == ACC_OVF || m > {4'h0, ACC_MAX}) ? ACC_OVF : m[9:0];
    endfunction

    // Write acceptance per index and value; reserved entry refused
    function automatic logic write_ok(input logic [9:0] idx, input logic [9:0] v);
        case (idx)
            IDX_RATE:    return v <= RATE_MAX;
            IDX_WORD:    return v >= WORD_MIN && v <= WORD_MAX;
            IDX_PARITY:  return v <= PARITY_MAX;
            IDX_TIMEOUT: return v <= TIMEOUT_MAX;
            IDX_FLOW:    return v <= FLOW_MAX;
            default:     return 1'b0;
        endcase
    endfunction

    // ****************************************************************
    // Parser signals
    // ****************************************************************
    hsb_state_e state;
    hsb_rsp_e   rsp_kind;
    logic [9:0] idx_acc, val_acc;
    logic       idx_seen, val_seen;
    logic [1:0] plus_run, eq_run;
    logic [7:0] qry_value;
    logic [3:0] pos;
    logic [3:0] eff_pos;
    logic [3:0] last_pos;
    logic [7:0] rsp_char;
    logic       is_digit;
    logic [3:0] digit;
    logic       rsp_step;
    logic       rsp_done;
    logic       wr_en;
    logic       rd_hit;
    logic [7:0] rd_value;
    logic [7:0] idx_h, idx_t, idx_o;
    logic [7:0] val_h, val_t, val_o;
    logic [15:0] div_cnt, div_len;

    // Character classification
    always_comb begin
        is_digit = rx_data >= CH_0 && rx_data <= CH_9;
        digit    = 4'(rx_data - CH_0);
    end

    // Read decode of the settings table
    always_comb begin
        rd_hit   = 1'b1;
        rd_value = 8'h00;
        case (idx_acc)
            IDX_RATE:    rd_value = serial_rate_select;
            IDX_WORD:    rd_value = serial_word_length;
            IDX_PARITY:  rd_value = serial_parity_select;
            IDX_TIMEOUT: rd_value = serial_timeout_ms;
            IDX_BUFCAP:  rd_value = serial_buffer_capacity;
            IDX_FLOW:    rd_value = serial_flow_control_enable;
            default:     rd_hit   = 1'b0;
        endcase
    end

    // Write strobe at carriage return of a valid set command
    always_comb begin
        wr_en = rx_valid && state == HSB_VAL && rx_data == CH_CR && val_seen
                && write_ok(idx_acc, val_acc);
    end

    // ****************************************************************
    // Command parser
    // ****************************************************************

    // Character-by-character walk through escapes and set/query lines
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= HSB_BIN;
            rsp_kind  <= HSB_RSP_OK;
            idx_acc   <= 10'h000;
            val_acc   <= 10'h000;
            idx_seen  <= 1'b0;
            val_seen  <= 1'b0;
            plus_run  <= 2'h0;
            eq_run    <= 2'h0;
            qry_value <= 8'h00;
        end else if (state == HSB_RESP) begin
            if (rsp_step && rsp_done) begin
                state <= HSB_LINE;
            end
        end else if (rx_valid) begin
            plus_run <= (rx_data == CH_PLUS) ? plus_run + 2'h1 : 2'h0;
            eq_run   <= (rx_data == CH_EQ) ? eq_run + 2'h1 : 2'h0;
            case (state)
                HSB_BIN: begin
                    if (rx_data == CH_PLUS && plus_run == RUN_LAST) begin
                        state    <= HSB_LINE;
                        plus_run <= 2'h0;
                    end
                end
                HSB_LINE: begin
                    if (rx_data == CH_PLUS && plus_run == RUN_LAST) begin
                        state    <= HSB_RESP;
                        rsp_kind <= HSB_RSP_OK;
                        plus_run <= 2'h0;
                    end else if (rx_data == CH_EQ && eq_run == RUN_LAST) begin
                        state  <= HSB_BIN;
                        eq_run <= 2'h0;
                    end else if (rx_data == CH_A) begin
                        state <= HSB_GOTA;
                    end else if (rx_data != CH_PLUS && rx_data != CH_EQ
                                 && rx_data != CH_CR) begin
                        state <= HSB_SKIP;
                    end
                end
                HSB_GOTA: state <= (rx_data == CH_T) ? HSB_GOTT : HSB_SKIP;
                HSB_GOTT: begin
                    state    <= (rx_data == CH_S) ? HSB_IDX : HSB_SKIP;
                    idx_acc  <= 10'h000;
                    val_acc  <= 10'h000;
                    idx_seen <= 1'b0;
                    val_seen <= 1'b0;
                end
                HSB_IDX: begin
                    if (is_digit) begin
                        idx_acc  <= acc_step(idx_acc, digit);
                        idx_seen <= 1'b1;
                    end else if (rx_data == CH_QM && idx_seen) begin
                        state <= HSB_QRY;
                    end else if (rx_data == CH_EQ && idx_seen) begin
                        state <= HSB_VAL;
                    end else begin
                        state <= HSB_SKIP;
                    end
                end
                HSB_QRY: begin
                    if (rx_data == CH_CR) begin
                        state     <= HSB_RESP;
                        rsp_kind  <= rd_hit ? HSB_RSP_QRY : HSB_RSP_ERR;
                        qry_value <= rd_value;
                    end else begin
                        state <= HSB_SKIP;
                    end
                end
                HSB_VAL: begin
                    if (is_digit) begin
                        val_acc  <= acc_step(val_acc, digit);
                        val_seen <= 1'b1;
                    end else if (rx_data == CH_CR) begin
                        state    <= HSB_RESP;
                        rsp_kind <= wr_en ? HSB_RSP_OK : HSB_RSP_ERR;
                    end else begin
                        state <= HSB_SKIP;
                    end
                end
                HSB_SKIP: begin
                    if (rx_data == CH_CR) begin
                        state    <= HSB_RESP;
                        rsp_kind <= HSB_RSP_ERR;
                    end
                end
                default: state <= HSB_BIN;
            endcase
        end
    end

    // ****************************************************************
    // Settings registers
    // ****************************************************************

    // Settings, loaded only by an accepted set command; capacity stays fixed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serial_rate_select         <= RST_RATE;
            serial_word_length         <= RST_WORD;
            serial_parity_select       <= RST_PARITY;
            serial_timeout_ms          <= RST_TIMEOUT;
            serial_flow_control_enable <= RST_FLOW;
            serial_buffer_capacity     <= RST_BUFCAP;
        end else if (wr_en) begin
            case (idx_acc)
                IDX_RATE:    serial_rate_select         <= val_acc[7:0];
                IDX_WORD:    serial_word_length         <= val_acc[7:0];
                IDX_PARITY:  serial_parity_select       <= val_acc[7:0];
                IDX_TIMEOUT: serial_timeout_ms          <= val_acc[7:0];
                IDX_FLOW:    serial_flow_control_enable <= val_acc[7:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Reply transmitter
    // ****************************************************************

    // Decimal digits of index and queried value
    hsb_dec_ascii u_idx_digits (
        .value (idx_acc[7:0]),
        .hund  (idx_h),
        .tens  (idx_t),
        .ones  (idx_o)
    );

    hsb_dec_ascii u_val_digits (
        .value (qry_value),
        .hund  (val_h),
        .tens  (val_t),
        .ones  (val_o)
    );

    // Leading zeros of the value are skipped; pick current character
    always_comb begin
        eff_pos = pos;
        if (rsp_kind == HSB_RSP_QRY && val_h == CH_0) begin
            if (pos == POS_VH) begin
                eff_pos = (val_t == CH_0) ? POS_VO : POS_VT;
            end else if (pos == POS_VT && val_t == CH_0) begin
                eff_pos = POS_VO;
            end
        end
        case (rsp_kind)
            HSB_RSP_OK:  last_pos = LAST_OK;
            HSB_RSP_ERR: last_pos = LAST_ERR;
            default:     last_pos = LAST_QRY;
        endcase
        rsp_char = CH_CR;
        if (eff_pos != last_pos) begin
            case (rsp_kind)
                HSB_RSP_OK:  rsp_char = CH_O;
                HSB_RSP_ERR: rsp_char = (eff_pos == 4'h0) ? CH_E
                                      : (eff_pos == 4'h3) ? CH_ERR1 : CH_0;
                default: begin
                    case (eff_pos)
                        4'h0:    rsp_char = CH_A;
                        4'h1:    rsp_char = CH_T;
                        4'h2:    rsp_char = CH_S;
                        4'h3:    rsp_char = idx_h;
                        4'h4:    rsp_char = idx_t;
                        4'h5:    rsp_char = idx_o;
                        4'h6:    rsp_char = CH_EQ;
                        4'h7:    rsp_char = val_h;
                        4'h8:    rsp_char = val_t;
                        default: rsp_char = val_o;
                    endcase
                end
            endcase
        end
        rsp_step = state == HSB_RESP && (!tx_valid || tx_ready);
        rsp_done = eff_pos == last_pos;
    end

    // Character output with valid/ready hand-off, and the text mode flag
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            pos      <= 4'h0;
            text_command_mode <= 1'b0;
        end else begin
            text_command_mode <= state != HSB_BIN;  // Lags the parser
            if (rsp_step) begin
                tx_valid <= 1'b1;
                tx_data  <= rsp_char;
                pos      <= eff_pos + 4'h1;
            end else if (tx_ready) begin
                tx_valid <= 1'b0;
            end
            if (state != HSB_RESP) begin
                pos <= 4'h0;
            end
        end
    end

    // ****************************************************************
    // Line rate divider
    // ****************************************************************

    // One-cycle tick at the selected bit rate
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt   <= 16'h0000;
            div_len   <= 16'h0001;
            rate_tick <= 1'b0;
        end else begin
            div_len <= hsb_rate_div(serial_rate_select);
            if (div_cnt + 16'h0001 >= div_len) begin
                div_cnt   <= 16'h0000;
                rate_tick <= 1'b1;
            end else begin
                div_cnt   <= div_cnt + 16'h0001;
                rate_tick <= 1'b0;
            end
        end
    end

endmodule

//--- test/hsb_settings_bank_chk.sv
`timescale 1ns/1ns
// ****************************************************************
// Port checks for the settings bank
// ****************************************************************
module hsb_settings_bank_chk
    import hsb_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Text link
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_ready,
    // Settings and status
    input  wire logic [7:0] serial_rate_select,
    input  wire logic [7:0] serial_word_length,
    input  wire logic [7:0] serial_parity_select,
    input  wire logic [7:0] serial_timeout_ms,
    input  wire logic [7:0] serial_buffer_capacity,
    input  wire logic [7:0] serial_flow_control_enable,
    input  wire logic       text_command_mode,
    input  wire logic       rate_tick
);
    // Tick spacing in cycles for each rate code
    localparam logic [15:0] PER [10] = '{16'h0057, 16'h00ae, 16'h0104, 16'h0209, 16'h0412,
                                         16'h0823, 16'h1047, 16'h208d, 16'h015b, 16'h411b};
    logic [15:0] tick_gap;
    logic [1:0]  ticks_seen;
    logic [7:0]  last_rate;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Cycles since last tick; only gaps after two ticks at a steady rate count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_gap   <= 16'h0000;
            ticks_seen <= 2'h0;
            last_rate  <= 8'h02;
        end else begin
            last_rate <= serial_rate_select;
            tick_gap  <= rate_tick ? 16'h0001 : tick_gap + 16'h0001;
            if (serial_rate_select != last_rate) begin
                ticks_seen <= 2'h0;
            end else if (rate_tick && ticks_seen != 2'h2) begin
                ticks_seen <= ticks_seen + 2'h1;
            end
        end
    end

    AST_BUFCAP_FIXED: assert property (serial_buffer_capacity == 8'h80)
        else $error("buffer capacity not 128");
    AST_RATE_CODE: assert property (serial_rate_select <= 8'h09)
        else $error("rate code out of range");
    AST_WORD_LEN: assert property (serial_word_length inside {8'h08, 8'h09})
        else $error("word length not 8 or 9");
    AST_PARITY_CODE: assert property (serial_parity_select <= 8'h04)
        else $error("parity code out of range");
    AST_FLOW_CODE: assert property (serial_flow_control_enable <= 8'h01)
        else $error("flow control not 0 or 1");
    AST_BIN_HOLDS: assert property (!text_command_mode && !$past(text_command_mode) |->
        $stable({serial_rate_select, serial_word_length, serial_parity_select,
                 serial_timeout_ms, serial_flow_control_enable}))
        else $error("setting changed outside text mode");
    AST_TX_STANDS: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("reply character dropped before acceptance");
    AST_TX_TEXT: assert property (tx_valid |-> text_command_mode)
        else $error("reply outside text mode");
    AST_TICK_GAP: assert property (rate_tick && ticks_seen == 2'h2 &&
        serial_rate_select == last_rate && serial_rate_select <= 8'h09 |->
        tick_gap == PER[serial_rate_select[3:0]])
        else $error("rate tick spacing wrong");

    // Main scenarios
    cover property (tx_valid && !tx_ready);
    cover property ($rose(text_command_mode));
    cover property (rate_tick && ticks_seen == 2'h2 && serial_rate_select == 8'h09);
endmodule

bind hsb_settings_bank hsb_settings_bank_chk u_chk (
    .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .serial_rate_select(serial_rate_select), .serial_word_length(serial_word_length),
    .serial_parity_select(serial_parity_select), .serial_timeout_ms(serial_timeout_ms),
    .serial_buffer_capacity(serial_buffer_capacity),
    .serial_flow_control_enable(serial_flow_control_enable),
    .text_command_mode(text_command_mode), .rate_tick(rate_tick)
);

//--- test/hsb_host_model.sv
`timescale 1ns/1ns
// ****************************************************************
// Host that types text commands and collects replies
// ****************************************************************
module hsb_host_model
    import hsb_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Characters to the bank
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    // Replies from the bank
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    logic         slow  = 1'b0;   // Stall every other reply cycle
    logic [127:0] reply = '0;     // Reply characters, newest rightmost
    int           crs   = 0;      // Reply terminators accepted

    initial begin
        rx_valid <= 1'b0;
        rx_data  <= 8'h00;
        tx_ready <= 1'b0;
    end

    // Accept reply characters, promptly or with stalls
    always @(posedge clk) begin
        tx_ready <= slow ? ~tx_ready : 1'b1;
        if (tx_valid && tx_ready) begin
            reply <= {reply[119:0], tx_data};
            if (tx_data == 8'h0d) begin
                crs <= crs + 1;
            end
        end
    end

    // Types one character a cycle, first character leftmost; reserved entries are written,
    // and set commands typed in binary mode, only where a scenario probes refusal
    task automatic send(input logic [127:0] cmd, input bit want);
        int c0;
        c0 = crs;
        reply <= '0;
        for (int k = 15; k >= 0; k--) begin
            if (cmd[k*8+:8] != 8'h00) begin
                @(posedge clk);
                rx_valid <= 1'b1;
                rx_data  <= cmd[k*8+:8];
            end
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_data  <= ~rx_data;   // Idle line shows no stale character
        for (int n = 0; n < 300 && want && crs == c0; n++) begin
            @(posedge clk);
        end
        @(posedge clk);
    endtask
endmodule

//--- test/test_host_serial_settings_bank.sv
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %0h seen %0h", nm, exp, got); end end
// ****************************************************************
// Self-checking bench for the settings bank
// ****************************************************************
module test_host_serial_settings_bank
    import hsb_pkg::*;
();
    typedef struct packed {
        logic [127:0] cmd;
        logic [127:0] rsp;
    } hsb_row_s;

    logic        clk;
    logic        rst_n;
    logic        rx_valid;
    logic [7:0]  rx_data;
    logic        tx_valid;
    logic [7:0]  tx_data;
    logic        tx_ready;
    logic [7:0]  rate;
    logic [7:0]  word;
    logic [7:0]  parity;
    logic [7:0]  tmo;
    logic [7:0]  bufcap;
    logic [7:0]  flow;
    logic        text_command_mode;
    logic        rate_tick;
    logic [15:0] gap;
    int          errors  = 0;
    int          checked = 0;

    // Tick spacing for each rate code
    logic [15:0] per [10] = '{16'h0057, 16'h00ae, 16'h0104, 16'h0209, 16'h0412,
                              16'h0823, 16'h1047, 16'h208d, 16'h015b, 16'h411b};
    // Commands beside their expected replies
    hsb_row_s rows [15] = '{
        '{"ATS101=9\r", "O\r"}, '{"ATS0101?\r", "ATS101=9\r"}, '{"ATS101=10\r", "E001\r"},
        '{"ATS102=9\r", "O\r"}, '{"ATS102=7\r", "E001\r"}, '{"ATS103=4\r", "O\r"},
        '{"ATS103=5\r", "E001\r"}, '{"ATS104=255\r", "O\r"}, '{"ATS104?\r", "ATS104=255\r"},
        '{"ATS104=256\r", "E001\r"}, '{"ATS106=1\r", "O\r"}, '{"ATS106=2\r", "E001\r"},
        '{"ATS105?\r", "ATS105=128\r"}, '{"ATS105=1\r", "E001\r"}, '{"ATS107?\r", "E001\r"}};

    hsb_settings_bank u_dut (
        .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .serial_rate_select(rate), .serial_word_length(word), .serial_parity_select(parity),
        .serial_timeout_ms(tmo), .serial_buffer_capacity(bufcap),
        .serial_flow_control_enable(flow), .text_command_mode(text_command_mode),
        .rate_tick(rate_tick)
    );

    hsb_host_model u_host (
        .clk(clk), .rst_n(rst_n), .rx_valid(rx_valid), .rx_data(rx_data),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready)
    );

    // Clock of 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Print counts and verdict, then stop
    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Factory values after any reset
    task check_defaults;
        `CHK("rate", 8'h02, rate);
        `CHK("word", 8'h08, word);
        `CHK("parity", 8'h00, parity);
        `CHK("timeout", 8'h08, tmo);
        `CHK("bufcap", 8'h80, bufcap);
        `CHK("flow", 8'h00, flow);
        `CHK("text mode", 1'b0, text_command_mode);
    endtask

    // Cycles up to the next tick
    task next_tick;
        gap = 16'h0000;
        do begin
            @(negedge clk);
            gap++;
        end while (rate_tick !== 1'b1 && gap < 16'h5000);
    endtask

    // Watchdog well past the expected run length
    initial begin
        #(100 * 90000);
        errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check_defaults();
        u_host.send("+++", 1'b0);
        for (int i = 0; i < 15; i++) begin
            u_host.send(rows[i].cmd, 1'b1);
            `CHK("reply", rows[i].rsp, u_host.reply);
        end
        `CHK("rate", 8'h09, rate);
        `CHK("word", 8'h09, word);
        `CHK("parity", 8'h04, parity);
        `CHK("timeout", 8'hff, tmo);
        `CHK("bufcap", 8'h80, bufcap);
        `CHK("flow", 8'h01, flow);
        for (int p = 0; p < 5; p++) begin
            u_host.send({"ATS103=", 8'h30 + 8'(p), 8'h0d}, 1'b1);
            `CHK("parity code", 8'(p), parity);
        end
        for (int c = 0; c < 10; c++) begin
            u_host.send({"ATS101=", 8'h30 + 8'(c), 8'h0d}, 1'b1);
            `CHK("rate code", 8'(c), rate);
            next_tick();
            next_tick();
            `CHK("tick gap", per[c], gap);
        end
        u_host.slow <= 1'b1;
        u_host.send("ATS102?\r", 1'b1);
        u_host.slow <= 1'b0;
        `CHK("stalled reply", 128'("ATS102=9\r"), u_host.reply);
        u_host.send("+++", 1'b1);
        `CHK("repeat escape", 128'("O\r"), u_host.reply);
        u_host.send("===", 1'b0);
        u_host.send("ATS104=5\r", 1'b0);
        repeat (20) @(negedge clk);
        `CHK("binary mode", 1'b0, text_command_mode);
        `CHK("binary ignored", 8'hff, tmo);
        @(posedge clk) rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check_defaults();
        u_host.send("+++", 1'b0);
        u_host.send("ATS104=20\r", 1'b1);
        `CHK("timeout set", 8'h14, tmo);
        report_and_stop();
    end
endmodule
